// ---- verification/pcc_pos_source_model.sv ----
// Encoder 1 actual position source, one register stage.
// Assumes the bench commands a position on clk_in.
`timescale 1ns/100ps
module pcc_pos_source_model (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] cmd_in,
   output logic      [31:0] pos_out
);
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pos_out <= 32'h0000_0000;
      end else begin
         pos_out <= cmd_in;
      end
   end
endmodule

// ---- verification/pcc_properties.sv ----
// Checker for the position compare top: register port and channel status.
// Assumes it is bound to pcc_position_compare and sees only its ports.
`timescale 1ns/100ps
module pcc_properties
   import pcc_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic [31:0] pos_in,
   input wire logic        wr_en_in,
   input wire logic        rd_en_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic [15:0] rdata_out,
   input wire logic        rd_valid_out,
   input wire logic        err_out,
   input wire logic        ch3_status_out,
   input wire logic        ch4_status_out
);
   logic [15:0] run3_r;
   logic [15:0] run4_r;
   logic [3:0]  mask_r;
   logic        run_wr;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   assign run_wr = wr_en_in && (addr_in == ADDR_CH3_RUN || addr_in == ADDR_CH4_RUN);

   // Shadow of accepted run codes and group mask
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         run3_r <= RST_CODE;
         run4_r <= RST_CODE;
         mask_r <= RST_GROUP;
      end else if (wr_en_in) begin
         if (addr_in == ADDR_CH3_RUN && wdata_in <= RUN_MAX) begin
            run3_r <= wdata_in;
         end
         if (addr_in == ADDR_CH4_RUN && wdata_in <= RUN_MAX) begin
            run4_r <= wdata_in;
         end
         if (addr_in == ADDR_GROUP_MASK && wdata_in <= GROUP_MAX) begin
            mask_r <= wdata_in[3:0];
         end
      end
   end

   a_read_valid_pulse: assert property (rd_en_in && !wr_en_in |=> rd_valid_out)
      else $error("read not answered");
   a_no_stray_valid: assert property (!(rd_en_in && !wr_en_in) |=> !rd_valid_out)
      else $error("read valid without read");
   a_bad_run_err: assert property (run_wr && wdata_in > RUN_MAX |=> err_out)
      else $error("run code above range accepted");
   a_good_run_quiet: assert property (run_wr && wdata_in <= RUN_MAX |=> !err_out)
      else $error("legal run code refused");
   a_bad_crit_err: assert property (wr_en_in && (addr_in == ADDR_CH3_CRIT || addr_in == ADDR_CH4_CRIT)
      && wdata_in > CRIT_MAX |=> err_out)
      else $error("criterion above range accepted");
   a_bad_src_err: assert property (wr_en_in && (addr_in == ADDR_CH3_SRC || addr_in == ADDR_CH4_SRC)
      && wdata_in != SRC_ENC1 |=> err_out)
      else $error("source other than encoder 1 accepted");
   a_bad_mask_err: assert property (wr_en_in && addr_in == ADDR_GROUP_MASK && wdata_in > GROUP_MAX
      |=> err_out)
      else $error("group mask above range accepted");
   a_set_forces_one: assert property (run3_r == RUN_OFF_SET && !mask_r[GROUP_BIT_CH3]
      |=> ch3_status_out)
      else $error("ch3 status not forced high");
   a_clr_forces_zero: assert property (run4_r == RUN_OFF_CLR && !mask_r[GROUP_BIT_CH4]
      |=> !ch4_status_out)
      else $error("ch4 status not forced low");
   a_keep_holds_state: assert property (run3_r == RUN_OFF_KEEP && !mask_r[GROUP_BIT_CH3]
      |=> $stable(ch3_status_out))
      else $error("ch3 status moved while stopped");

   c_read_seen: cover property (rd_valid_out);
   c_refusal_seen: cover property (err_out);
   c_mask_run: cover property (mask_r[GROUP_BIT_CH4] && ch4_status_out);
endmodule

bind pcc_position_compare pcc_properties u_props (.clk_in(clk_in), .rstn_in(rstn_in), .pos_in(pos_in),
   .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
   .rd_valid_out(rd_valid_out), .err_out(err_out), .ch3_status_out(ch3_status_out),
   .ch4_status_out(ch4_status_out));

// ---- verification/tb.sv ----
// Self-checking bench for position compare channels 3 and 4.
// Assumes the position source model and the bound checker.
`timescale 1ns/100ps
module tb;
   import pcc_pkg::*;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [31:0] pos_cmd = 32'h0;
   logic [31:0] pos;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] addr = 16'h0;
   logic [15:0] wdata = 16'h0;
   logic [15:0] rdata;
   logic        rd_valid;
   logic        err;
   logic        st3;
   logic        st4;
   logic        last_err;
   logic [15:0] rd_d;
   logic [31:0] seed = 32'hfdfb;
   int          err_count = 0;
   int          n_compared = 0;

   always #5 clk_in = ~clk_in;

   pcc_pos_source_model u_pos (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(pos_cmd), .pos_out(pos));
   pcc_position_compare u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .pos_in(pos), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rd_valid_out(rd_valid),
      .err_out(err), .ch3_status_out(st3), .ch4_status_out(st4));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic exp_m(input logic signed [31:0] p, a, b, input logic [15:0] c);
      logic signed [31:0] lo;
      logic signed [31:0] hi;
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      case (c)
         CRIT_GE_A:      return p >= a;
         CRIT_LE_A:      return p <= a;
         CRIT_IN_BASIC:  return p >= a && p <= b;
         CRIT_OUT_BASIC: return p < a || p > b;
         CRIT_IN_EXT:    return p >= lo && p <= hi;
         default:        return p < lo || p > hi;
      endcase
   endfunction

   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_in);
      wr_en <= 1'b0;
      #1;
      last_err = err;
   endtask

   task automatic wr32(input logic [15:0] a, input logic [31:0] v);
      wr(a, v[31:16]);
      wr(a + 16'h0001, v[15:0]);
   endtask

   task automatic rd(input logic [15:0] a);
      int i;
      @(posedge clk_in);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1;
      last_err = err;
      for (i = 0; i < 4 && rd_valid !== 1'b1; i++) step(1);
      rd_d = rdata;
      if (i == 4) begin
         chk("read handshake", 32'h1, 32'h0);
         wrap_up();
      end
   endtask

   initial begin
      logic [15:0]        crit [2];
      logic signed [31:0] va [2];
      logic signed [31:0] vb [2];
      logic signed [31:0] p;
      logic [31:0]        v;
      int                 k;
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (k = 0; k < 20; k++) begin
         rd(ADDR_CH3_RUN + 16'(k));
         chk("reset word", 32'h0, 32'(rd_d));
      end
      wr(ADDR_CH3_RUN, RUN_ON);
      wr(ADDR_CH4_RUN, RUN_ON);
      // Random settings with boundary positions, every criterion on both channels
      for (k = 0; k < 60; k++) begin
         for (int c = 0; c < 2; c++) begin
            v = xs();
            crit[c] = (k < 6) ? 16'(k) : 16'(v % 6);
            va[c] = (k % 4 == 0) ? xs() : {{24{v[15]}}, v[15:8]};
            vb[c] = {{24{v[23]}}, v[23:16]};
            wr(c ? ADDR_CH4_CRIT : ADDR_CH3_CRIT, crit[c]);
            wr32(c ? ADDR_CH4_VAL_A : ADDR_CH3_VAL_A, va[c]);
            wr32(c ? ADDR_CH4_VAL_B : ADDR_CH3_VAL_B, vb[c]);
         end
         v = xs();
         case (v[2:0])
            3'h0: p = va[0];
            3'h1: p = vb[0];
            3'h2: p = va[1];
            3'h3: p = vb[1] + 1;
            3'h4: p = va[0] - 1;
            default: p = {{24{v[31]}}, v[31:24]};
         endcase
         @(posedge clk_in);
         pos_cmd <= p;
         step(2);
         chk("ch3 status", 32'(exp_m(p, va[0], vb[0], crit[0])), 32'(st3));
         chk("ch4 status", 32'(exp_m(p, va[1], vb[1], crit[1])), 32'(st4));
      end
      rd(ADDR_CH4_VAL_B + 16'h0001);
      chk("ch4 B low", 32'(vb[1][15:0]), 32'(rd_d));
      wr(ADDR_CH3_CRIT, CRIT_GE_A);
      wr32(ADDR_CH3_VAL_A, p);
      step(1);
      chk("ch3 A equal", 32'h1, 32'(st3));
      wr32(ADDR_CH3_VAL_A, p + 1);
      step(1);
      chk("ch3 A above", 32'h0, 32'(st3));
      rd(ADDR_CH3_VAL_A);
      chk("ch3 A high", 32'(16'((p + 1) >>> 16)), 32'(rd_d));
      wr(ADDR_CH3_RUN, RUN_OFF_SET);
      step(1);
      chk("ch3 forced one", 32'h1, 32'(st3));
      wr(ADDR_CH3_RUN, RUN_OFF_KEEP);
      step(3);
      chk("ch3 kept one", 32'h1, 32'(st3));
      wr(ADDR_CH3_RUN, RUN_OFF_CLR);
      step(1);
      chk("ch3 forced zero", 32'h0, 32'(st3));
      wr32(ADDR_CH3_VAL_A, p);
      wr(ADDR_CH3_RUN, RUN_OFF_KEEP);
      step(3);
      chk("ch3 kept zero", 32'h0, 32'(st3));
      wr(ADDR_CH3_RUN, 16'h0004);
      chk("run 4 refused", 32'h1, 32'(last_err));
      rd(ADDR_CH3_RUN);
      chk("run after refusal", 32'(RUN_OFF_KEEP), 32'(rd_d));
      wr(ADDR_CH3_RUN, RUN_ON);
      step(1);
      chk("ch3 restarted", 32'h1, 32'(st3));
      wr(ADDR_CH4_CRIT, CRIT_GE_A);
      wr32(ADDR_CH4_VAL_A, p);
      wr(ADDR_GROUP_MASK, 16'h0008);
      wr(ADDR_CH4_RUN, RUN_OFF_CLR);
      step(1);
      chk("ch4 run by mask", 32'h1, 32'(st4));
      rd(ADDR_STATUS);
      chk("status word", 32'hf, 32'(rd_d[3:0]));
      wr(ADDR_GROUP_MASK, 16'h0010);
      chk("mask 16 refused", 32'h1, 32'(last_err));
      wr(ADDR_GROUP_MASK, 16'h0000);
      step(1);
      chk("ch4 cleared", 32'h0, 32'(st4));
      wr(ADDR_CH4_CRIT, 16'h0006);
      chk("criterion 6 refused", 32'h1, 32'(last_err));
      wr(ADDR_CH4_SRC, 16'h0001);
      chk("source 1 refused", 32'h1, 32'(last_err));
      wr(ADDR_CH4_SRC, SRC_ENC1);
      chk("source 0 taken", 32'h0, 32'(last_err));
      wr(ADDR_STATUS, 16'h0001);
      chk("status write refused", 32'h1, 32'(last_err));
      wr(ADDR_CH3_SRC, 16'h0002);
      chk("ch3 source 2 refused", 32'h1, 32'(last_err));
      wr(ADDR_CH3_RUN, RUN_OFF_CLR);
      wr(ADDR_GROUP_MASK, 16'h0004);
      step(1);
      chk("ch3 run by mask", 32'h1, 32'(st3));
      rd(16'h0b40);
      chk("unmapped read", 32'h10000, {15'h0, last_err, rd_d});
      wrap_up();
   end
endmodule

// ---- verilog/pcc_channel.sv ----
// Status bit of one channel under its run control.
// Assumes the match input is combinational from the same clock.
`timescale 1ns/100ps
module pcc_channel
   import pcc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [15:0] run_in,
   input  wire logic        group_en_in,
   input  wire logic        match_in,
   output logic             running_out,
   output logic             status_out
);

   logic status_r;
   logic status_nxt;

   assign running_out = group_en_in || (run_in == RUN_ON);

   always_comb begin
      status_nxt = status_r;
      if (running_out) begin
         status_nxt = match_in;
      end else begin
         case (run_in)
            RUN_OFF_KEEP: status_nxt = status_r;
            RUN_OFF_CLR:  status_nxt = 1'b0;
            RUN_OFF_SET:  status_nxt = 1'b1;
            default:      status_nxt = status_r;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         status_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign status_out = status_r;

endmodule

// ---- verilog/pcc_compare.sv ----
// Combinational comparison of one channel.
// Assumes position and limits are signed values on the same clock.
`timescale 1ns/100ps
module pcc_compare
   import pcc_pkg::*;
(
   input  wire logic signed [31:0] pos_in,
   input  wire logic signed [31:0] val_a_in,
   input  wire logic signed [31:0] val_b_in,
   input  wire logic        [15:0] crit_in,
   output logic                    match_out
);

   logic signed [31:0] lo;
   logic signed [31:0] hi;
   logic               in_basic;
   logic               in_ext;

   // Extended window accepts the limits in either order
   always_comb begin
      lo       = (val_a_in <= val_b_in) ? val_a_in : val_b_in;
      hi       = (val_a_in <= val_b_in) ? val_b_in : val_a_in;
      in_basic = (pos_in >= val_a_in) && (pos_in <= val_b_in);
      in_ext   = (pos_in >= lo) && (pos_in <= hi);
   end

   always_comb begin
      case (crit_in)
         CRIT_GE_A:      match_out = (pos_in >= val_a_in);
         CRIT_LE_A:      match_out = (pos_in <= val_a_in);
         CRIT_IN_BASIC:  match_out = in_basic;
         CRIT_OUT_BASIC: match_out = (pos_in < val_a_in) || (pos_in > val_b_in);
         CRIT_IN_EXT:    match_out = in_ext;
         CRIT_OUT_EXT:   match_out = !in_ext;
         default:        match_out = 1'b0;
      endcase
   end

endmodule

// ---- verilog/pcc_pkg.sv ----
// Constants for the position compare channels 3 and 4.
// Assumes 16-bit parameter words at fieldbus addresses; 32-bit values span two words, high word first.
package pcc_pkg;

   // Word addresses
   localparam logic [15:0] ADDR_CH3_RUN     = 16'hb18;
   localparam logic [15:0] ADDR_CH4_RUN     = 16'hb1a;
   localparam logic [15:0] ADDR_CH3_CRIT    = 16'hb1c;
   localparam logic [15:0] ADDR_CH4_CRIT    = 16'hb1e;
   localparam logic [15:0] ADDR_CH3_SRC     = 16'hb20;
   localparam logic [15:0] ADDR_CH4_SRC     = 16'hb22;
   localparam logic [15:0] ADDR_CH3_VAL_A   = 16'hb24;
   localparam logic [15:0] ADDR_CH3_VAL_B   = 16'hb26;
   localparam logic [15:0] ADDR_CH4_VAL_A   = 16'hb28;
   localparam logic [15:0] ADDR_CH4_VAL_B   = 16'hb2a;
   localparam logic [15:0] ADDR_GROUP_MASK  = 16'hb2c;
   localparam logic [15:0] ADDR_STATUS      = 16'hb30;

   // Reset values
   localparam logic [15:0] RST_CODE         = 16'h0000;
   localparam logic [31:0] RST_VALUE        = 32'h0000_0000;
   localparam logic [3:0]  RST_GROUP        = 4'h0;

   // Run codes
   localparam logic [15:0] RUN_OFF_KEEP     = 16'h0000;
   localparam logic [15:0] RUN_ON           = 16'h0001;
   localparam logic [15:0] RUN_OFF_CLR      = 16'h0002;
   localparam logic [15:0] RUN_OFF_SET      = 16'h0003;
   localparam logic [15:0] RUN_MAX          = 16'h0003;

   // Criterion codes
   localparam logic [15:0] CRIT_GE_A        = 16'h0000;
   localparam logic [15:0] CRIT_LE_A        = 16'h0001;
   localparam logic [15:0] CRIT_IN_BASIC    = 16'h0002;
   localparam logic [15:0] CRIT_OUT_BASIC   = 16'h0003;
   localparam logic [15:0] CRIT_IN_EXT      = 16'h0004;
   localparam logic [15:0] CRIT_OUT_EXT     = 16'h0005;
   localparam logic [15:0] CRIT_MAX         = 16'h0005;

   // Source codes
   localparam logic [15:0] SRC_ENC1         = 16'h0000;

   // Group mask
   localparam logic [15:0] GROUP_MAX        = 16'h000f;
   localparam int          GROUP_BIT_CH3    = 2;
   localparam int          GROUP_BIT_CH4    = 3;

   // Status word field positions
   localparam int          STAT_BIT_CH3     = 0;
   localparam int          STAT_BIT_CH4     = 1;
   localparam int          STAT_BIT_RUN3    = 2;
   localparam int          STAT_BIT_RUN4    = 3;

endpackage

// ---- verilog/pcc_position_compare.sv ----
// Parameter words and two compare channels of the position register function.
// Assumes the parameter port and the position come from logic on clk_in.
`timescale 1ns/100ps
module pcc_position_compare
   import pcc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] pos_in,
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] rdata_out,
   output logic             rd_valid_out,
   output logic             err_out,
   output logic             ch3_status_out,
   output logic             ch4_status_out
);

   // Replace one half of a 32-bit value; high word sits at the even address
   function automatic logic [31:0] put_half(input logic [31:0] old, input logic low_half,
                                            input logic [15:0] data);
      logic [31:0] res;
      res = old;
      if (low_half) begin
         res[15:0] = data;
      end else begin
         res[31:16] = data;
      end
      return res;
   endfunction

   // Select one half of a 32-bit value
   function automatic logic [15:0] get_half(input logic [31:0] val, input logic low_half);
      return low_half ? val[15:0] : val[31:16];
   endfunction

   logic [15:0] ch3_run_control_r;
   logic [15:0] ch4_run_control_r;
   logic [15:0] ch3_criterion_select_r;
   logic [15:0] ch4_criterion_select_r;
   logic [15:0] ch3_position_source_r;
   logic [15:0] ch4_position_source_r;
   logic [31:0] ch3_compare_value_a_r;
   logic [31:0] ch3_compare_value_b_r;
   logic [31:0] ch4_compare_value_a_r;
   logic [31:0] ch4_compare_value_b_r;
   logic [3:0]  channel_group_enable_mask_r;
   logic [15:0] rdata_r;
   logic        rd_valid_r;
   logic        err_r;

   logic        wr_run3;
   logic        wr_run4;
   logic        wr_crit3;
   logic        wr_crit4;
   logic        wr_src3;
   logic        wr_src4;
   logic        wr_a3;
   logic        wr_b3;
   logic        wr_a4;
   logic        wr_b4;
   logic        wr_group;
   logic        wr_bad;
   logic        rd_bad;
   logic        low_half;
   logic [15:0] rdata_nxt;

   logic        match3;
   logic        match4;
   logic        running3;
   logic        running4;
   logic [31:0] src_pos3;
   logic [31:0] src_pos4;

   assign low_half = addr_in[0];

   // Write decode; values out of the allowed range are refused and flagged
   always_comb begin
      wr_run3  = 1'b0;
      wr_run4  = 1'b0;
      wr_crit3 = 1'b0;
      wr_crit4 = 1'b0;
      wr_src3  = 1'b0;
      wr_src4  = 1'b0;
      wr_a3    = 1'b0;
      wr_b3    = 1'b0;
      wr_a4    = 1'b0;
      wr_b4    = 1'b0;
      wr_group = 1'b0;
      wr_bad   = 1'b0;
      if (!wr_en_in) begin
         wr_bad = 1'b0;
      end else if (addr_in == ADDR_CH3_RUN) begin
         wr_run3 = (wdata_in <= RUN_MAX);
         wr_bad  = !wr_run3;
      end else if (addr_in == ADDR_CH4_RUN) begin
         wr_run4 = (wdata_in <= RUN_MAX);
         wr_bad  = !wr_run4;
      end else if (addr_in == ADDR_CH3_CRIT) begin
         wr_crit3 = (wdata_in <= CRIT_MAX);
         wr_bad   = !wr_crit3;
      end else if (addr_in == ADDR_CH4_CRIT) begin
         wr_crit4 = (wdata_in <= CRIT_MAX);
         wr_bad   = !wr_crit4;
      end else if (addr_in == ADDR_CH3_SRC) begin
         wr_src3 = (wdata_in == SRC_ENC1);
         wr_bad  = !wr_src3;
      end else if (addr_in == ADDR_CH4_SRC) begin
         wr_src4 = (wdata_in == SRC_ENC1);
         wr_bad  = !wr_src4;
      end else if (addr_in[15:1] == ADDR_CH3_VAL_A[15:1]) begin
         wr_a3 = 1'b1;
      end else if (addr_in[15:1] == ADDR_CH3_VAL_B[15:1]) begin
         wr_b3 = 1'b1;
      end else if (addr_in[15:1] == ADDR_CH4_VAL_A[15:1]) begin
         wr_a4 = 1'b1;
      end else if (addr_in[15:1] == ADDR_CH4_VAL_B[15:1]) begin
         wr_b4 = 1'b1;
      end else if (addr_in == ADDR_GROUP_MASK) begin
         wr_group = (wdata_in <= GROUP_MAX);
         wr_bad   = !wr_group;
      end else begin
         wr_bad = 1'b1;
      end
   end

   // Run controls
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ch3_run_control_r <= RST_CODE;
         ch4_run_control_r <= RST_CODE;
      end else begin
         if (wr_run3) begin
            ch3_run_control_r <= wdata_in;
         end
         if (wr_run4) begin
            ch4_run_control_r <= wdata_in;
         end
      end
   end

   // Criteria
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ch3_criterion_select_r <= RST_CODE;
         ch4_criterion_select_r <= RST_CODE;
      end else begin
         if (wr_crit3) begin
            ch3_criterion_select_r <= wdata_in;
         end
         if (wr_crit4) begin
            ch4_criterion_select_r <= wdata_in;
         end
      end
   end

   // Position sources
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ch3_position_source_r <= SRC_ENC1;
         ch4_position_source_r <= SRC_ENC1;
      end else begin
         if (wr_src3) begin
            ch3_position_source_r <= wdata_in;
         end
         if (wr_src4) begin
            ch4_position_source_r <= wdata_in;
         end
      end
   end

   // Comparison values, one 16-bit half per write
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ch3_compare_value_a_r <= RST_VALUE;
         ch3_compare_value_b_r <= RST_VALUE;
         ch4_compare_value_a_r <= RST_VALUE;
         ch4_compare_value_b_r <= RST_VALUE;
      end else begin
         if (wr_a3) begin
            ch3_compare_value_a_r <= put_half(ch3_compare_value_a_r, low_half, wdata_in);
         end
         if (wr_b3) begin
            ch3_compare_value_b_r <= put_half(ch3_compare_value_b_r, low_half, wdata_in);
         end
         if (wr_a4) begin
            ch4_compare_value_a_r <= put_half(ch4_compare_value_a_r, low_half, wdata_in);
         end
         if (wr_b4) begin
            ch4_compare_value_b_r <= put_half(ch4_compare_value_b_r, low_half, wdata_in);
         end
      end
   end

   // Group mask
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         channel_group_enable_mask_r <= RST_GROUP;
      end else if (wr_group) begin
         channel_group_enable_mask_r <= wdata_in[3:0];
      end
   end

   // Read decode
   always_comb begin
      rdata_nxt = 16'h0000;
      rd_bad    = 1'b0;
      if (addr_in == ADDR_CH3_RUN) begin
         rdata_nxt = ch3_run_control_r;
      end else if (addr_in == ADDR_CH4_RUN) begin
         rdata_nxt = ch4_run_control_r;
      end else if (addr_in == ADDR_CH3_CRIT) begin
         rdata_nxt = ch3_criterion_select_r;
      end else if (addr_in == ADDR_CH4_CRIT) begin
         rdata_nxt = ch4_criterion_select_r;
      end else if (addr_in == ADDR_CH3_SRC) begin
         rdata_nxt = ch3_position_source_r;
      end else if (addr_in == ADDR_CH4_SRC) begin
         rdata_nxt = ch4_position_source_r;
      end else if (addr_in[15:1] == ADDR_CH3_VAL_A[15:1]) begin
         rdata_nxt = get_half(ch3_compare_value_a_r, low_half);
      end else if (addr_in[15:1] == ADDR_CH3_VAL_B[15:1]) begin
         rdata_nxt = get_half(ch3_compare_value_b_r, low_half);
      end else if (addr_in[15:1] == ADDR_CH4_VAL_A[15:1]) begin
         rdata_nxt = get_half(ch4_compare_value_a_r, low_half);
      end else if (addr_in[15:1] == ADDR_CH4_VAL_B[15:1]) begin
         rdata_nxt = get_half(ch4_compare_value_b_r, low_half);
      end else if (addr_in == ADDR_GROUP_MASK) begin
         rdata_nxt = {12'h000, channel_group_enable_mask_r};
      end else if (addr_in == ADDR_STATUS) begin
         rdata_nxt[STAT_BIT_CH3]  = ch3_status_out;
         rdata_nxt[STAT_BIT_CH4]  = ch4_status_out;
         rdata_nxt[STAT_BIT_RUN3] = running3;
         rdata_nxt[STAT_BIT_RUN4] = running4;
      end else begin
         rd_bad = 1'b1;
      end
   end

   // Read answer and error pulse
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_r    <= 16'h0000;
         rd_valid_r <= 1'b0;
         err_r      <= 1'b0;
      end else begin
         rd_valid_r <= rd_en_in && !wr_en_in;
         err_r      <= wr_bad || (rd_en_in && !wr_en_in && rd_bad);
         if (rd_en_in && !wr_en_in) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign rdata_out    = rdata_r;
   assign rd_valid_out = rd_valid_r;
   assign err_out      = err_r;

   // Only the first encoder exists as a source
   assign src_pos3 = (ch3_position_source_r == SRC_ENC1) ? pos_in : 32'h0000_0000;
   assign src_pos4 = (ch4_position_source_r == SRC_ENC1) ? pos_in : 32'h0000_0000;

   pcc_compare u_cmp3 (
      .pos_in    (src_pos3),
      .val_a_in  (ch3_compare_value_a_r),
      .val_b_in  (ch3_compare_value_b_r),
      .crit_in   (ch3_criterion_select_r),
      .match_out (match3)
   );

   pcc_compare u_cmp4 (
      .pos_in    (src_pos4),
      .val_a_in  (ch4_compare_value_a_r),
      .val_b_in  (ch4_compare_value_b_r),
      .crit_in   (ch4_criterion_select_r),
      .match_out (match4)
   );

   pcc_channel u_ch3 (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .run_in      (ch3_run_control_r),
      .group_en_in (channel_group_enable_mask_r[GROUP_BIT_CH3]),
      .match_in    (match3),
      .running_out (running3),
      .status_out  (ch3_status_out)
   );

   pcc_channel u_ch4 (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .run_in      (ch4_run_control_r),
      .group_en_in (channel_group_enable_mask_r[GROUP_BIT_CH4]),
      .match_in    (match4),
      .running_out (running4),
      .status_out  (ch4_status_out)
   );

endmodule
